// ### src/scsp_pkg.sv
// Purpose: Shared constants and types for the synthesizer serial config port
// Assumes: 100 MHz ref_clk, config space of 128 bytes
// Notes: Byte layout beyond the select table is a plain default
package scsp_pkg;
  localparam int CFG_BYTES = 128;
  localparam logic [4:0] ADDR_FIXED = 5'h1B;
  localparam logic [6:0] OFS_IDENT = 7'h00;
  localparam logic [6:0] OFS_ADDR = 7'h01;
  localparam logic [6:0] OFS_PINMODE = 7'h02;
  localparam logic [6:0] OFS_Y1SEL = 7'h04;
  localparam logic [6:0] OFS_BYTECNT = 7'h09;
  localparam logic [6:0] OFS_PLL1 = 7'h10;
  localparam logic [6:0] OFS_PLL_STEP = 7'h10;
  localparam logic [6:0] OFS_SSC_LO = 7'h00;
  localparam logic [6:0] OFS_SSC_MID = 7'h01;
  localparam logic [6:0] OFS_SSC_HI = 7'h02;
  localparam logic [6:0] OFS_FREQ = 7'h03;
  localparam logic [6:0] OFS_OUT = 7'h05;
  localparam int BIT_EE_BUSY = 6;
  localparam int BIT_PINMODE = 6;
  localparam int CMD_SINGLE = 7;
  localparam logic [7:0] RST_IDENT = 8'h5A; // Arbitrary identification value
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_PINMODE = 8'h00;
  localparam logic [7:0] RST_OUTSEL = 8'hFE;
  localparam logic [7:0] RST_BYTECNT = 8'h40;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int EE_WRITE_NS = 10000;
  localparam int CLK_NS = 10;
  localparam int EE_WRITE_CYC = (EE_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int NUM_PLL = 4;
  typedef struct packed {
    logic [2:0] spreadCode;
    logic freqChoiceBit;
    logic pllOutputChoiceBit;
  } scsp_pll_sel_t;
  typedef struct packed {
    scsp_pll_sel_t [NUM_PLL-1:0] pll;
    logic loneOutputChoice;
  } scsp_ctrl_t;
  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } scsp_link_t;
endpackage

// ### src/scsp_line_sync.sv
// Purpose: Two-stage synchroniser and edge finder for the serial lines
// Assumes: Lines are asynchronous to ref_clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module scsp_line_sync (
  // Clock and reset
  input wire logic refClk,
  input wire logic resetN,
  // Raw lines
  input wire scsp_pkg::scsp_link_t linkRaw,
  // Synchronised lines and edges
  output scsp_pkg::scsp_link_t linkSync,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  import scsp_pkg::*;
  scsp_link_t meta_reg;
  scsp_link_t sync_reg;
  scsp_link_t last_reg;
  always_ff @(posedge refClk)
  begin
    if (!resetN)
    begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      last_reg <= 2'h3;
    end
    else
    begin
      meta_reg <= linkRaw;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign linkSync = sync_reg;
  assign sclRise = sync_reg.sclIn & ~last_reg.sclIn;
  assign sclFall = ~sync_reg.sclIn & last_reg.sclIn;
  assign startSeen = sync_reg.sclIn & last_reg.sclIn & last_reg.sdaIn & ~sync_reg.sdaIn;
  assign stopSeen = sync_reg.sclIn & last_reg.sclIn & ~last_reg.sdaIn & sync_reg.sdaIn;
endmodule
`default_nettype wire

// ### src/scsp_config_port.sv
// Purpose: Serial slave port, config bytes and select decode of the synthesizer
// Assumes: EEPROM image held in flip-flops; lines open-drain
// Notes: Pin mode taken from stored image, forced to serial while output supply low
//
// Summary of operation
// - Three select pins index one of eight stored control settings.
// - Three-bit spread code per PLL, 000 off up to 111 two percent.
// - Frequency choice bit picks frequency 0 or 1 per PLL.
// - Output choice bit picks state 0 or 1 for both outputs of a PLL.
// - Lone output choice bit picks one of two generic states.
// - Dual pins are serial lines unless stored byte 02 bit 6 set.
// - In select mode serial port off, except while output supply grounded.
// - Dual pins in serial use read as zero selects.
// - Factory setting 0 all outputs off, setting 1 all on, freq 0.
// - Reset loads factory values into both the live configuration and the EEPROM image.
// - Acts as seven-bit addressed slave on the two-wire bus.
// - Address is 11011 then two programmable bits from byte 01.
// - Address byte lowest bit: 1 read, 0 write.
// - Byte write, byte read, block write and block read supported.
// - Command bit 7 single versus block, bits 6:0 start offset.
// - Block bytes ascend by offset, MSB first, stop after any byte.
// - Block read returns byte count bytes; master reads them all.
// - Each written byte lands in the live register at once.
// - EEPROM cycle copies live bytes, refuses writes, busy flag visible.
`timescale 1ns/1ps
`default_nettype none
module scsp_config_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Dual-function and select pins
  input wire logic selectPinZero,
  input wire logic sdaSelectOneIn,
  input wire logic sclSelectTwoIn,
  input wire logic outputSupplyLow,
  output logic sdaOut,
  output logic sdaOe,
  // EEPROM cycle request and status
  input wire logic eeWriteStart,
  output logic eepromBusyFlag,
  // Decoded control
  output scsp_pkg::scsp_ctrl_t ctrlOut,
  output logic serialMode
);
  import scsp_pkg::*;
  typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_SKIP} scsp_st_t;
  logic [7:0] cfg_reg [CFG_BYTES];
  logic [7:0] ee_reg [CFG_BYTES];
  scsp_st_t state_reg;
  scsp_st_t after_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic [6:0] ptr_reg;
  logic single_reg;
  logic [7:0] left_reg;
  logic ackDrive_reg;
  logic busy_reg;
  logic [15:0] eeCnt_reg;
  logic [2:0] selMeta_reg;
  logic [2:0] selSync_reg;
  scsp_ctrl_t ctrl_reg;
  logic serial_reg;
  logic supplyMeta_reg;
  logic supplySync_reg;
  scsp_link_t linkRaw;
  scsp_link_t linkSync;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic portOn;
  logic [2:0] selIdx;

  function automatic logic [7:0] rst_byte(input logic [6:0] ofs);
    logic [7:0] v;
    v = RST_ZERO;
    if (ofs == OFS_IDENT) v = RST_IDENT;
    if (ofs == OFS_ADDR) v = RST_ADDR;
    if (ofs == OFS_PINMODE) v = RST_PINMODE;
    if (ofs == OFS_BYTECNT) v = RST_BYTECNT;
    if (ofs == OFS_Y1SEL) v = RST_OUTSEL;
    for (int p = 0; p < NUM_PLL; p++)
    begin
      if (ofs == 7'(OFS_PLL1 + 7'(p) * OFS_PLL_STEP + OFS_OUT)) v = RST_OUTSEL;
    end
    return v;
  endfunction

  function automatic logic [6:0] pll_ofs(input int p, input logic [6:0] ofs);
    return 7'(OFS_PLL1 + 7'(p) * OFS_PLL_STEP + ofs);
  endfunction

  assign linkRaw = {sclSelectTwoIn, sdaSelectOneIn};

  scsp_line_sync u_sync (
    .refClk(ref_clk),
    .resetN(reset_n),
    .linkRaw(linkRaw),
    .linkSync(linkSync),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  assign portOn = serial_reg;

  // Pin mode and select sampling
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      selMeta_reg <= 3'h0;
      selSync_reg <= 3'h0;
      supplyMeta_reg <= 1'b0;
      supplySync_reg <= 1'b0;
      serial_reg <= 1'b1;
    end
    else
    begin
      selMeta_reg <= {sclSelectTwoIn, sdaSelectOneIn, selectPinZero};
      selSync_reg <= selMeta_reg;
      supplyMeta_reg <= outputSupplyLow;
      supplySync_reg <= supplyMeta_reg;
      serial_reg <= ~ee_reg[OFS_PINMODE][BIT_PINMODE] | supplySync_reg;
    end
  end

  assign selIdx = serial_reg ? {2'b00, selSync_reg[0]} : selSync_reg;

  // Control decode from selected row
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ctrl_reg <= '0;
    else
    begin
      ctrl_reg.loneOutputChoice <= cfg_reg[OFS_Y1SEL][selIdx];
      for (int p = 0; p < NUM_PLL; p++)
      begin
        ctrl_reg.pll[p].spreadCode <= {cfg_reg[pll_ofs(p, OFS_SSC_HI)][selIdx],
          cfg_reg[pll_ofs(p, OFS_SSC_MID)][selIdx],
          cfg_reg[pll_ofs(p, OFS_SSC_LO)][selIdx]};
        ctrl_reg.pll[p].freqChoiceBit <= cfg_reg[pll_ofs(p, OFS_FREQ)][selIdx];
        ctrl_reg.pll[p].pllOutputChoiceBit <= cfg_reg[pll_ofs(p, OFS_OUT)][selIdx];
      end
    end
  end

  // EEPROM cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      busy_reg <= 1'b0;
      eeCnt_reg <= 16'h0000;
    end
    else if (!busy_reg && eeWriteStart)
    begin
      busy_reg <= 1'b1;
      eeCnt_reg <= 16'(EE_WRITE_CYC - 1);
    end
    else if (busy_reg)
    begin
      if (eeCnt_reg == 16'h0000)
        busy_reg <= 1'b0;
      else
        eeCnt_reg <= eeCnt_reg - 16'h0001;
    end
  end

  // EEPROM image, loaded from factory values and updated on cycle end
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < CFG_BYTES; i++)
    begin
      if (!reset_n)
        ee_reg[i] <= rst_byte(7'(i));
      else if (busy_reg && eeCnt_reg == 16'h0000)
        ee_reg[i] <= cfg_reg[i];
    end
  end

  // Bus state machine
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !portOn)
    begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      ptr_reg <= 7'h00;
      single_reg <= 1'b0;
      left_reg <= 8'h00;
      ackDrive_reg <= 1'b0;
    end
    else if (startSeen)
    begin
      state_reg <= ST_ADDR;
      bit_reg <= 4'h0;
      ackDrive_reg <= 1'b0;
    end
    else if (stopSeen)
    begin
      state_reg <= ST_IDLE;
      ackDrive_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (sclRise)
          begin
            shift_reg <= {shift_reg[6:0], linkSync.sdaIn};
            bit_reg <= bit_reg + 4'h1;
          end
          if (sclFall && bit_reg == 4'h8)
          begin
            bit_reg <= 4'h0;
            if (state_reg == ST_ADDR)
            begin
              if (shift_reg[7:1] == {ADDR_FIXED, cfg_reg[OFS_ADDR][1:0]})
              begin
                ackDrive_reg <= 1'b1;
                state_reg <= ST_ACK;
                after_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
                left_reg <= single_reg ? 8'h01 : cfg_reg[OFS_BYTECNT];
              end
              else
                state_reg <= ST_SKIP;
            end
            else if (state_reg == ST_CMD)
            begin
              single_reg <= shift_reg[CMD_SINGLE];
              ptr_reg <= shift_reg[6:0];
              ackDrive_reg <= 1'b1;
              state_reg <= ST_ACK;
              after_reg <= ST_WDATA;
            end
            else
            begin
              ackDrive_reg <= ~busy_reg;
              state_reg <= busy_reg ? ST_SKIP : ST_ACK;
              after_reg <= single_reg ? ST_SKIP : ST_WDATA;
              if (!busy_reg)
                ptr_reg <= ptr_reg + 7'h01;
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            ackDrive_reg <= 1'b0;
            state_reg <= after_reg;
            if (after_reg == ST_RDATA)
            begin
              shift_reg <= cfg_reg[ptr_reg];
              ackDrive_reg <= ~cfg_reg[ptr_reg][7];
              bit_reg <= 4'h1;
            end
          end
        end
        ST_RDATA:
        begin
          if (sclFall)
          begin
            if (bit_reg == 4'h8)
            begin
              ackDrive_reg <= 1'b0;
              state_reg <= ST_RACK;
              ptr_reg <= ptr_reg + 7'h01;
              left_reg <= left_reg - 8'h01;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              ackDrive_reg <= ~shift_reg[6];
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (sclRise)
          begin
            if (linkSync.sdaIn || left_reg == 8'h00)
              state_reg <= ST_SKIP;
            else
            begin
              state_reg <= ST_ACK;
              after_reg <= ST_RDATA;
            end
          end
        end
        ST_SKIP, ST_IDLE:
          ackDrive_reg <= 1'b0;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Live configuration bytes
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < CFG_BYTES; i++)
    begin
      if (!reset_n)
        cfg_reg[i] <= rst_byte(7'(i));
      else if (portOn && state_reg == ST_WDATA && !startSeen && !stopSeen && sclFall &&
               bit_reg == 4'h8 && !busy_reg && ptr_reg == 7'(i))
      begin
        cfg_reg[i] <= shift_reg;
        if (i == int'(OFS_ADDR))
          cfg_reg[i][BIT_EE_BUSY] <= busy_reg;
      end
      else if (i == int'(OFS_ADDR))
        cfg_reg[i][BIT_EE_BUSY] <= busy_reg;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      eepromBusyFlag <= 1'b0;
    else
      eepromBusyFlag <= busy_reg;
  end

  assign sdaOut = 1'b0;
  assign sdaOe = ackDrive_reg;
  assign ctrlOut = ctrl_reg;
  assign serialMode = serial_reg;

  a_ee_busy_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(busy_reg) |-> busy_reg [*8]) else $error("EEPROM busy dropped early");
  a_sel_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
    serial_reg |-> selIdx[2:1] == 2'b00) else $error("Select high bits in serial use");
  a_port_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !serial_reg |=> !ackDrive_reg) else $error("Drove line with port off");
  a_pin_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    outputSupplyLow |-> ##3 serial_reg) else $error("Supply low not serial");
  a_no_wr_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy_reg && $past(busy_reg) |-> $stable(cfg_reg[OFS_PINMODE])) else $error("Write while busy");
  a_busy_vis: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy_reg |-> ##2 (cfg_reg[OFS_ADDR][BIT_EE_BUSY] || !busy_reg)) else $error("Busy not visible");
  a_ctrl_freq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 ctrl_reg.pll[0].freqChoiceBit == $past(cfg_reg[OFS_PLL1 + OFS_FREQ][selIdx]))
    else $error("Freq choice mismatch");
  a_ack_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    startSeen && serial_reg |=> state_reg == ST_ADDR) else $error("Start not taken");
  sequence s_ee_begin;
    !busy_reg && eeWriteStart;
  endsequence
  a_ee_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_ee_begin |=> busy_reg && eeCnt_reg == 16'(EE_WRITE_CYC - 1))
    else $error("EEPROM cycle not begun");
endmodule
`default_nettype wire

// ### testbench/scsp_bus_model.sv
// Purpose: Two-wire bus master model facing the config port
// Assumes: Data line open-drain with pull-up, clock line driven by this model
// Notes: Clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none
module scsp_bus_model (
  // Bus lines
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLow,
  // Received bytes
  output logic rdStb,
  output logic [7:0] rdByte
);
  initial
  begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    rdStb = 1'b0;
    rdByte = 8'h00;
  end
  // One bit: data set mid-low, sampled mid-high, 125 ns period
  task automatic bitIo(input logic b, output logic s);
    #31.25 sdaLow = !b;
    #31.25 sclOut = 1'b1;
    #31.25 s = sdaLine;
    #31.25 sclOut = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    #31.25 sdaLow = 1'b0;
    #31.25 sclOut = 1'b1;
    #62.5 sdaLow = 1'b1;
    #62.5 sclOut = 1'b0;
  endtask
  // Stop, then both lines rest high
  task automatic stop();
    #31.25 sdaLow = 1'b1;
    #31.25 sclOut = 1'b1;
    #62.5 sdaLow = 1'b0;
    #62.5;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(!ack, s);
    rdByte = d;
    rdStb = 1'b1;
    #1 rdStb = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the synthesizer config port
// Assumes: Bus model on the dual pins, pins switch to plain selects
// Notes: Read bytes checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scsp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic selectPinZero = 1'b0;
  logic outputSupplyLow = 1'b0;
  logic eeWriteStart = 1'b0;
  logic useBus = 1'b1;
  logic pinOne = 1'b0;
  logic pinTwo = 1'b0;
  logic sdaOut, sdaOe, eepromBusyFlag, serialMode, sclOut, sdaLow, rdStb, ack;
  logic [7:0] rdByte;
  logic [7:0] sh [0:127];
  logic [7:0] txq [$];
  logic [7:0] expq [$];
  logic [7:0] pats [3] = '{8'hAA, 8'hCC, 8'hF0};
  logic [6:0] dev = {ADDR_FIXED, 2'b00};
  scsp_ctrl_t ctrlOut;
  int nFail = 0;
  int checked = 0;
  wire logic sdaLine = !(sdaOe && !sdaOut) && !sdaLow;
  wire logic sdaIn = useBus ? sdaLine : pinOne;
  wire logic sclIn = useBus ? sclOut : pinTwo;
  always #5 ref_clk = ~ref_clk;
  scsp_config_port i_scsp_config_port (.ref_clk(ref_clk), .reset_n(reset_n),
    .selectPinZero(selectPinZero), .sdaSelectOneIn(sdaIn), .sclSelectTwoIn(sclIn),
    .outputSupplyLow(outputSupplyLow), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .eeWriteStart(eeWriteStart), .eepromBusyFlag(eepromBusyFlag), .ctrlOut(ctrlOut),
    .serialMode(serialMode));
  scsp_bus_model i_scsp_bus_model (.sdaLine(sdaLine), .sclOut(sclOut), .sdaLow(sdaLow),
    .rdStb(rdStb), .rdByte(rdByte));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic sendb(input logic [7:0] d);
    logic a;
    i_scsp_bus_model.sendByte(d, a);
    ack = ack & a;
  endtask
  // Address with write direction, command, then queued bytes
  task automatic wr(input logic [7:0] cmd);
    ack = 1'b1;
    i_scsp_bus_model.start();
    sendb({dev, 1'b0});
    sendb(cmd);
    while (txq.size() > 0) sendb(txq.pop_front());
    i_scsp_bus_model.stop();
  endtask
  // Command, repeated start, then n bytes each acknowledged
  task automatic rd(input logic [7:0] cmd, input int n);
    logic [7:0] d;
    ack = 1'b1;
    i_scsp_bus_model.start();
    sendb({dev, 1'b0});
    sendb(cmd);
    i_scsp_bus_model.start();
    sendb({dev, 1'b1});
    repeat (n) i_scsp_bus_model.recvByte(1'b1, d);
    i_scsp_bus_model.stop();
  endtask
  task automatic put(input logic [6:0] o, input logic [7:0] v);
    sh[o] = v;
    txq.push_back(v);
    wr({1'b1, o});
    chk(32'(ack), 32'h1);
  endtask
  function automatic scsp_ctrl_t expCtrl(input logic [2:0] s);
    scsp_ctrl_t e;
    int b;
    for (int p = 0; p < NUM_PLL; p++)
    begin
      b = OFS_PLL1 + p * OFS_PLL_STEP;
      e.pll[p].spreadCode = {sh[b+OFS_SSC_HI][s], sh[b+OFS_SSC_MID][s], sh[b][s]};
      e.pll[p].freqChoiceBit = sh[b+OFS_FREQ][s];
      e.pll[p].pllOutputChoiceBit = sh[b+OFS_OUT][s];
    end
    e.loneOutputChoice = sh[OFS_Y1SEL][s];
    return e;
  endfunction
  task automatic rows(input int n);
    for (int s = 0; s < n; s++)
    begin
      cyc(1);
      {pinTwo, pinOne, selectPinZero} <= 3'(s);
      cyc(6);
      chk(32'(ctrlOut), 32'(expCtrl(3'(s))));
    end
  endtask
  always @(posedge rdStb)
  begin
    chk(32'(rdByte), 32'(expq.pop_front()));
  end
  initial
  begin
    #400000;
    nFail++;
    closeOut();
  end
  initial
  begin
    int b;
    logic [7:0] v;
    void'($urandom(9920));
    for (int i = 0; i < CFG_BYTES; i++) sh[i] = RST_ZERO;
    sh[OFS_IDENT] = RST_IDENT;
    sh[OFS_BYTECNT] = RST_BYTECNT;
    sh[OFS_Y1SEL] = RST_OUTSEL;
    for (int p = 0; p < NUM_PLL; p++) sh[OFS_PLL1 + p * OFS_PLL_STEP + OFS_OUT] = RST_OUTSEL;
    cyc(4);
    reset_n <= 1'b1;
    cyc(6);
    chk(32'(serialMode), 32'h1);
    chk(32'(eepromBusyFlag), 32'h0);
    chk(32'(sdaOut), 32'h0);
    chk(32'(sdaOe), 32'h0);
    rows(2);
    // Byte 0 is never written by the master
    for (int p = 0; p < NUM_PLL; p++)
    begin
      b = OFS_PLL1 + p * OFS_PLL_STEP;
      for (int i = 0; i < 6; i++)
      begin
        v = (i < 3) ? pats[i] ^ {8{p[i]}} : 8'($urandom());
        sh[b + i] = v;
        txq.push_back(v);
      end
      wr({1'b0, 7'(b)});
      chk(32'(ack), 32'h1);
    end
    put(OFS_Y1SEL, 8'($urandom()));
    put(OFS_BYTECNT, 8'h03);
    rows(2);
    for (int i = 0; i < 3; i++) expq.push_back(sh[OFS_PLL1 + i]);
    rd({1'b0, OFS_PLL1}, 3);
    put(OFS_ADDR, 8'h02);
    txq.push_back(8'h00);
    wr({1'b1, OFS_Y1SEL});
    chk(32'(ack), 32'h0);
    dev = {ADDR_FIXED, 2'b10};
    put(OFS_PINMODE, 8'h40);
    chk(32'(serialMode), 32'h1);
    cyc(1);
    eeWriteStart <= 1'b1;
    cyc(1);
    eeWriteStart <= 1'b0;
    cyc(3);
    chk(32'(eepromBusyFlag), 32'h1);
    expq.push_back(sh[OFS_ADDR] | 8'h40);
    rd({1'b1, OFS_ADDR}, 1);
    txq.push_back(8'h00);
    wr({1'b1, OFS_Y1SEL});
    chk(32'(ack), 32'h0);
    for (int i = 0; i < 2 * EE_WRITE_CYC && eepromBusyFlag !== 1'b0; i++) cyc(1);
    cyc(6);
    chk(32'(eepromBusyFlag), 32'h0);
    chk(32'(serialMode), 32'h0);
    useBus <= 1'b0;
    rows(8);
    useBus <= 1'b1;
    cyc(6);
    txq.push_back(8'h00);
    wr({1'b1, OFS_Y1SEL});
    chk(32'(ack), 32'h0);
    cyc(1);
    outputSupplyLow <= 1'b1;
    cyc(6);
    chk(32'(serialMode), 32'h1);
    rows(2);
    expq.push_back(8'h03);
    rd({1'b1, OFS_BYTECNT}, 1);
    cyc(4);
    chk(32'(expq.size()), 32'h0);
    closeOut();
  end
endmodule
`default_nettype wire
